/* File: core_model.sv */
/* core side: acknowledges each request with a one-cycle pulse while take_en
   is high; assumes level requests from the unit. */
`timescale 1ns/1ps
module core_model
  import irq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic take_en,
  input wire logic [irq_pkg::ext_count-1:0] ereq,
  input wire logic [irq_pkg::group_count-1:0] greq,
  output logic [irq_pkg::ext_count-1:0] eack,
  output logic [irq_pkg::group_count-1:0] gack
);
  // a held request is taken again only after a gap, like a real vector fetch
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      {eack, gack} <= '0;
    else
      {eack, gack} <= {ereq, greq} & ~{eack, gack} & {5{take_en}};
endmodule

/* File: external_and_pin_change_irq.sv */
/*
  external interrupt unit: two sense-selectable pins, three pin-change groups,
  flags, vector requests to the core, apb registers and a summary interrupt.
  assumes pins arrive synchronous to sys_clk and the core pulses an
  acknowledge input in the cycle it executes a vector.
*/
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module external_and_pin_change_irq
  import irq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [irq_pkg::ext_count-1:0] ext_irq_pins,
  input wire logic [7:0] change_pins_group0,
  input wire logic [6:0] change_pins_group1,
  input wire logic [7:0] change_pins_group2,
  input wire logic core_status_word_global,
  output logic [irq_pkg::ext_count-1:0] ext_irq_vector_req,
  output logic [irq_pkg::group_count-1:0] group_vector_req,
  input wire logic [irq_pkg::ext_count-1:0] ext_irq_vector_ack,
  input wire logic [irq_pkg::group_count-1:0] group_vector_ack,
  output logic irq
);
  import irq_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [3:0] sense;
    logic [1:0] ext_mask;
    logic [1:0] ext_flag;
    logic [2:0] grp_en;
    logic [2:0] grp_flag;
    logic [7:0] msk0;
    logic [6:0] msk1;
    logic [7:0] msk2;
    logic [1:0] ext_q;
    logic [23:0] chg_q;
    logic [4:0] ev_status;
    logic [4:0] ev_enable;
    logic [31:0] rdata;
    logic err;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic [23:0] all_pins;
  logic [23:0] all_masks;
  logic [23:0] changed;
  logic [2:0] grp_hit;
  logic [1:0] ext_hit;
  logic [1:0] ext_level;
  logic [1:0] ext_low;
  sense_t [1:0] mode;
  logic setup;
  logic wr;
  logic [7:0] idx;
  logic hit;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // group 1 has only seven pins; pin 15 is absent and stays quiet
  assign all_pins = {change_pins_group2, 1'b0, change_pins_group1, change_pins_group0};
  assign all_masks = {cur.msk2, 1'b0, cur.msk1, cur.msk0};
  assign mode[0] = sense_t'(cur.sense[sense0_msb:sense0_lsb]);
  assign mode[1] = sense_t'(cur.sense[sense1_msb:sense1_lsb]);

  // ****************************************************************
  // detection
  // ****************************************************************
  // sample against previous sample, so only a change between two edges counts
  assign changed = (all_pins ^ cur.chg_q) & all_masks;

  genvar g;
  generate
    for (g = 0; g < group_count; g++)
    begin : grp
      assign grp_hit[g] = |changed[g*pins_per_group +: pins_per_group];
      assign group_vector_req[g] = cur.grp_flag[g] & cur.grp_en[g]
                                   & core_status_word_global;
    end
    for (g = 0; g < ext_count; g++)
    begin : ext
      // pin level is read regardless of the port direction
      assign ext_low[g] = ~ext_irq_pins[g];
      assign ext_level[g] = (mode[g] == sense_low_level);
      // one continuous assignment per bit: separate processes may not share ext_hit
      assign ext_hit[g] =
        (mode[g] == sense_any_change) ? (ext_irq_pins[g] ^ cur.ext_q[g]) :
        (mode[g] == sense_falling) ? (cur.ext_q[g] & ~ext_irq_pins[g]) :
        (mode[g] == sense_rising) ? (~cur.ext_q[g] & ext_irq_pins[g]) :
        1'b0;
      // level mode requests straight from the pin while it stays low
      assign ext_irq_vector_req[g] = cur.ext_mask[g] & core_status_word_global
        & (ext_level[g] ? ext_low[g] : cur.ext_flag[g]);
    end
  endgenerate

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pstrb[0];
  assign idx = paddr[addr_msb:addr_lsb];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign prdata = cur.rdata;
  assign pslverr = cur.err;
  assign irq = |(cur.ev_status & cur.ev_enable);

  always_comb
  begin
    hit = 1'b1;
    rbyte = reset_byte;
    case (idx)
      idx_ext_irq_sense_control: rbyte = {4'h0, cur.sense};
      idx_ext_irq_enable_mask: rbyte = {6'h00, cur.ext_mask};
      idx_ext_irq_flags: rbyte = {6'h00, cur.ext_flag & ~ext_level};
      idx_pin_change_group_enable: rbyte = {5'h00, cur.grp_en};
      idx_pin_change_group_flags: rbyte = {5'h00, cur.grp_flag};
      idx_pin_change_mask_group0: rbyte = cur.msk0;
      idx_pin_change_mask_group1: rbyte = {1'b0, cur.msk1};
      idx_pin_change_mask_group2: rbyte = cur.msk2;
      idx_event_status: rbyte = {3'h0, cur.ev_status};
      idx_event_clear: rbyte = reset_byte;
      idx_event_enable: rbyte = {3'h0, cur.ev_enable};
      default: hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_cur = cur;
    next_cur.ext_q = ext_irq_pins;
    next_cur.chg_q = all_pins;
    if (setup)
    begin
      next_cur.rdata = {24'h000000, rbyte};
      next_cur.err = ~hit;
    end
    if (wr)
    begin
      case (idx)
        idx_ext_irq_sense_control: next_cur.sense = wbyte[3:0];
        idx_ext_irq_enable_mask: next_cur.ext_mask = wbyte[1:0];
        idx_pin_change_group_enable: next_cur.grp_en = wbyte[2:0];
        idx_pin_change_mask_group0: next_cur.msk0 = wbyte;
        idx_pin_change_mask_group1: next_cur.msk1 = wbyte[6:0];
        idx_pin_change_mask_group2: next_cur.msk2 = wbyte;
        idx_event_enable: next_cur.ev_enable = wbyte[4:0];
        default: next_cur.sense = cur.sense;
      endcase
    end
    // clears first, so a same-cycle event below wins
    next_cur.ext_flag = cur.ext_flag & ~ext_irq_vector_ack;
    next_cur.grp_flag = cur.grp_flag & ~group_vector_ack;
    if (wr && idx == idx_ext_irq_flags)
      next_cur.ext_flag = next_cur.ext_flag & ~wbyte[1:0];
    if (wr && idx == idx_pin_change_group_flags)
      next_cur.grp_flag = next_cur.grp_flag & ~wbyte[2:0];
    if (wr && idx == idx_event_clear)
      next_cur.ev_status = cur.ev_status & ~wbyte[4:0];
    next_cur.ext_flag = (next_cur.ext_flag | ext_hit) & ~ext_level;
    next_cur.grp_flag = next_cur.grp_flag | grp_hit;
    next_cur.ev_status[ev_ext0] = next_cur.ev_status[ev_ext0] | ext_hit[0]
                                  | (ext_level[0] & ext_low[0]);
    next_cur.ev_status[ev_ext1] = next_cur.ev_status[ev_ext1] | ext_hit[1]
                                  | (ext_level[1] & ext_low[1]);
    next_cur.ev_status[event_count-1:ev_group0] =
      next_cur.ev_status[event_count-1:ev_group0] | grp_hit;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cur.sense <= 4'h0;
      cur.ext_mask <= 2'h0;
      cur.ext_flag <= 2'h0;
      cur.grp_en <= 3'h0;
      cur.grp_flag <= 3'h0;
      cur.msk0 <= reset_byte;
      cur.msk1 <= 7'h00;
      cur.msk2 <= reset_byte;
      cur.ext_q <= 2'h3;
      cur.chg_q <= 24'h000000;
      cur.ev_status <= 5'h00;
      cur.ev_enable <= 5'h00;
      cur.rdata <= reset_word;
      cur.err <= 1'b0;
    end
    else
      cur <= next_cur;
  end

endmodule

/* File: irq_pkg.sv */
/*
  constants shared by the external and pin-change interrupt unit: register
  indices, field positions, reset values and sense encodings.
  assumes an apb register bus with 32-bit data, one aligned word per register.
*/
package irq_pkg;

  // ****************************************************************
  // register indices (byte address = index * 4)
  // ****************************************************************
  localparam logic [7:0] idx_ext_irq_enable_mask = 8'h1d;
  localparam logic [7:0] idx_pin_change_mask_group0 = 8'h6b;
  localparam logic [7:0] idx_pin_change_mask_group2 = 8'h6d;
  localparam logic [7:0] idx_ext_irq_sense_control = 8'h69;
  localparam logic [7:0] idx_ext_irq_flags = 8'h1c;
  localparam logic [7:0] idx_pin_change_group_enable = 8'h68;
  localparam logic [7:0] idx_pin_change_group_flags = 8'h1b;
  localparam logic [7:0] idx_pin_change_mask_group1 = 8'h6c;
  localparam logic [7:0] idx_event_status = 8'h70;
  localparam logic [7:0] idx_event_clear = 8'h71;
  localparam logic [7:0] idx_event_enable = 8'h72;
  localparam int addr_lsb = 2;
  localparam int addr_msb = 9;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int sense1_lsb = 2;
  localparam int sense1_msb = 3;
  localparam int sense0_lsb = 0;
  localparam int sense0_msb = 1;
  localparam int group1_pins = 7;
  localparam int pins_per_group = 8;
  localparam int group_count = 3;
  localparam int ext_count = 2;
  localparam int event_count = 5;
  localparam int ev_ext0 = 0;
  localparam int ev_ext1 = 1;
  localparam int ev_group0 = 2;

  // ****************************************************************
  // sense encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    sense_low_level = 2'h0,
    sense_any_change = 2'h1,
    sense_falling = 2'h2,
    sense_rising = 2'h3
  } sense_t;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [31:0] reset_word = 32'h0000_0000;

endpackage

/* File: irq_unit_assertions.sv */
/* port checker of the interrupt unit.
   assumes it is bound to the top and that all inputs move on sys_clk edges. */
`timescale 1ns/1ps
module irq_unit_assertions
  import irq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [irq_pkg::ext_count-1:0] ext_irq_pins,
  input wire logic [7:0] change_pins_group0,
  input wire logic core_status_word_global,
  input wire logic [irq_pkg::ext_count-1:0] ext_irq_vector_req,
  input wire logic [irq_pkg::group_count-1:0] group_vector_req,
  input wire logic [irq_pkg::ext_count-1:0] ext_irq_vector_ack,
  input wire logic [irq_pkg::group_count-1:0] group_vector_ack,
  input wire logic irq
);
  logic [2:0] wr_q;
  // a recent write may legally move a request, so those cycles are excused
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      wr_q <= '0;
    else
      wr_q <= {wr_q[1:0], psel && penable && pwrite};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($fell(rst) |-> !irq && !ext_irq_vector_req)
    else $error("request after reset");
  a_global_gate: assert property (!core_status_word_global |-> !group_vector_req)
    else $error("request without global bit");
  a_err_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on refused read");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ext_cause: assert property ($rose(ext_irq_vector_req[0]) |-> !ext_irq_pins[0] || |wr_q ||
    $rose(core_status_word_global) || $past(ext_irq_pins[0], 1) != $past(ext_irq_pins[0], 2)
    || $past(ext_irq_pins[0], 2) != $past(ext_irq_pins[0], 3)) else $error("ext req no cause");
  a_group_cause: assert property ($rose(group_vector_req[0]) |-> |wr_q ||
    $rose(core_status_word_global) || $past(change_pins_group0, 1) != $past(change_pins_group0, 2)
    || $past(change_pins_group0, 2) != $past(change_pins_group0, 3)) else $error("group no cause");
  a_ext_hold: assert property ($fell(ext_irq_vector_req[0]) |-> $past(ext_irq_vector_ack[0]) ||
    ext_irq_pins[0] || !core_status_word_global || |wr_q) else $error("ext req dropped");
  a_group_hold: assert property ($fell(group_vector_req[0]) |-> $past(group_vector_ack[0]) ||
    !core_status_word_global || |wr_q) else $error("group req dropped");
  cover property (group_vector_ack != 3'h0);
  cover property (pslverr);
  cover property (irq);
  cover property (ext_irq_vector_req != 2'h0);
endmodule
bind external_and_pin_change_irq irq_unit_assertions i_chk (.sys_clk(sys_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
  .ext_irq_pins(ext_irq_pins), .change_pins_group0(change_pins_group0), .irq(irq),
  .core_status_word_global(core_status_word_global), .ext_irq_vector_req(ext_irq_vector_req),
  .group_vector_req(group_vector_req), .ext_irq_vector_ack(ext_irq_vector_ack),
  .group_vector_ack(group_vector_ack));

/* File: testbench.sv */
/* self-checking bench of the interrupt unit with an apb master task.
   assumes the core model and the checker are compiled alongside. */
`timescale 1ns/1ps
module testbench;
  import irq_pkg::*;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, glob = 1, take_en = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, irq;
  logic [1:0] pins = 2'h3, ereq, eack;
  logic [7:0] g0 = '0, g2 = '0, o0, o2, ex;
  logic [6:0] g1 = '0, o1;
  logic [2:0] greq, gack;
  int error_cnt = 0, checks_done = 0;
  int regs[int], wmk[int];
  logic [7:0] ix[7] = '{8'h69, 8'h1d, 8'h68, 8'h6b, 8'h6c, 8'h6d, 8'h72};
  logic [7:0] wm[7] = '{8'h0f, 8'h03, 8'h07, 8'hff, 8'h7f, 8'hff, 8'h1f};
  external_and_pin_change_irq i_external_and_pin_change_irq (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_pins(pins),
    .change_pins_group0(g0), .change_pins_group1(g1), .change_pins_group2(g2),
    .core_status_word_global(glob), .ext_irq_vector_req(ereq), .group_vector_req(greq),
    .ext_irq_vector_ack(eack), .group_vector_ack(gack), .irq(irq));
  core_model i_core_model (.sys_clk(sys_clk), .rst(rst), .take_en(take_en), .ereq(ereq),
    .greq(greq), .eack(eack), .gack(gack));
  initial
    forever #10 sys_clk = ~sys_clk;
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // holds the request until pready is seen at an edge; one idle cycle after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, a, 2'h0};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    check("pready", 1, pready);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && wmk.exists(a))
      regs[a] = d & wmk[a];
    @(posedge sys_clk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #100us;
    error_cnt++;
    results;
  end
  initial
  begin
    void'($urandom(32'hf504a477));
    foreach (ix[k])
      wmk[ix[k]] = wm[k];
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (ix[k])
    begin
      apb(0, ix[k], 0);
      check("reset value", 0, rd);
    end
    apb(0, 8'h00, 0);
    check("unmapped", 1, pslverr);
    foreach (ix[k])
    begin
      apb(1, ix[k], $urandom);
      apb(0, ix[k], 0);
      check("register", regs[ix[k]], rd);
    end
    apb(1, 8'h1d, 3);
    for (int i = 0; i < 2; i++)
      for (int m = 0; m < 4; m++)
      begin
        apb(1, 8'h69, m << (2 * i));
        apb(1, 8'h1c, 3);
        pins[i] <= 1'b0;
        repeat (3) @(posedge sys_clk);
        ex = (m == 1 || m == 2) << i;
        check("ext req", ex[i] | (m == 0), ereq[i]);
        apb(0, 8'h1c, 0);
        check("ext flag fall", ex, rd);
        apb(1, 8'h1c, 3);
        pins[i] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(0, 8'h1c, 0);
        check("ext flag rise", (m == 1 || m == 3) << i, rd);
      end
    apb(1, 8'h68, 7);
    repeat (4)
    begin
      for (int k = 3; k < 6; k++)
        apb(1, ix[k], $urandom);
      apb(1, 8'h1b, 7);
      {o0, o1, o2} = {g0, g1, g2};
      {g0, g1, g2} <= 23'($urandom);
      repeat (3) @(posedge sys_clk);
      ex = {|((o2 ^ g2) & regs[8'h6d]), |((o1 ^ g1) & regs[8'h6c]), |((o0 ^ g0) & regs[8'h6b])};
      check("group req", ex, greq);
      apb(0, 8'h1b, 0);
      check("group flags", ex, rd);
      glob <= 1'b0;
      @(posedge sys_clk);
      check("gated req", 0, {greq, ereq});
      glob <= 1'b1;
      take_en <= 1'b1;
      repeat (4) @(posedge sys_clk);
      take_en <= 1'b0;
      apb(0, 8'h1b, 0);
      check("acked flags", 0, rd);
    end
    apb(1, 8'h71, 8'h1f);
    apb(0, 8'h70, 0);
    check("status clear", 0, rd);
    apb(1, 8'h69, 2);
    pins[0] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pins[0] <= 1'b1;
    apb(1, 8'h72, 0);
    check("irq masked", 0, irq);
    apb(1, 8'h72, 1);
    check("irq raised", 1, irq);
    apb(1, 8'h71, 1);
    check("irq cleared", 0, irq);
    results;
  end
endmodule
